// ---- hdl/clk_div_if.sv ----
// Carrier between the selector and its tick divider.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface clk_div_if;
  logic                          srcTick;
  logic [clk_sel_pkg::DIV_W-1:0] divSel;
  logic                          outTick;
  logic                          idle;

  modport ctl (output srcTick, output divSel, input outTick, input idle);
  modport div (input srcTick, input divSel, output outTick, output idle);
endinterface : clk_div_if

// ---- hdl/clk_sel_pkg.sv ----
// Constants, encodings and register map of the system clock source selector.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package clk_sel_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          WB_AW         = 4;
  localparam int          WB_DW         = 32;
  localparam logic [3:0]  ADR_SYS_MODE  = 4'h0;
  localparam logic [3:0]  ADR_TIME_BASE = 4'h4;
  localparam logic [3:0]  ADR_STATUS    = 4'h8;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          DIV_W         = 3;
  localparam int          LP_BIT        = 0;
  localparam int          SPEED_BIT     = 3;
  localparam logic        SPEED_RST     = 1'h1;
  localparam logic [2:0]  DIV_RST       = 3'h0;
  localparam logic        LP_RST        = 1'h0;

  // ----------------------------------------------------------------
  // Source frequencies in kHz (slow crystal in Hz), for reference only
  // ----------------------------------------------------------------
  localparam int          FAST_XTAL_MIN_KHZ  = 400;
  localparam int          FAST_XTAL_MAX_KHZ  = 16000;
  localparam int          EXT_RC_KHZ         = 8000;
  localparam int          XTAL_RANGE_KHZ     = 1000;
  localparam int          RESONATOR_KHZ      = 455;
  localparam int          SLOW_XTAL_HZ       = 32768;
  localparam int          SLOW_RC_KHZ        = 32;

  // ----------------------------------------------------------------
  // Configuration option encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_EXT_FAST_CRYSTAL = 2'h0,
    SRC_EXT_RC_SOURCE    = 2'h1,
    SRC_EXT_CLOCK_INPUT  = 2'h2,
    SRC_INT_FAST_RC      = 2'h3
  } fast_src_t;

  typedef enum logic {
    SRC_EXT_SLOW_CRYSTAL = 1'h0,
    SRC_INT_SLOW_RC      = 1'h1
  } slow_src_t;

  typedef enum logic [1:0] {
    XTAL_LOW  = 2'h0,
    XTAL_HIGH = 2'h1,
    XTAL_455  = 2'h2
  } xtal_range_t;

  typedef enum logic [1:0] {
    RC_4MHZ  = 2'h0,
    RC_8MHZ  = 2'h1,
    RC_12MHZ = 2'h2
  } rc_freq_t;

  localparam int NUM_FAST = 4;
  localparam int NUM_SLOW = 2;

  // Clock handover state, Gray along the usual path
  typedef enum logic {
    SW_RUN  = 1'h0,
    SW_PEND = 1'h1
  } switch_state_t;

endpackage : clk_sel_pkg

// ---- hdl/clk_tick_divider.sv ----
// Divides the selected source tick by two to the power of divSel.
// Assumes divSel only changes while idle is high.
`timescale 1ns/10ps
module clk_tick_divider #(
  parameter int CNT_W = 7
) (
  input  wire logic clk,
  input  wire logic arst_n,
  clk_div_if.div    bus
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } div_state_t;

  div_state_t q;
  div_state_t d;
  logic [CNT_W-1:0] last;

  assign last     = CNT_W'((1 << bus.divSel) - 1);
  assign bus.idle = (q.cnt == '0);
  assign bus.outTick = q.tick;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (bus.srcTick) begin
      if (q.cnt == last) begin
        d.cnt  = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_DIV_PERIOD: assert property (
    q.tick |-> $past(bus.srcTick) && ($past(q.cnt) == $past(last)))
    else $error("divided tick without a full period");

  AST_DIV_FIRES: assert property (
    (bus.srcTick && q.cnt == last) |=> q.tick && q.cnt == '0)
    else $error("divided tick missing at period end");

endmodule : clk_tick_divider

// ---- hdl/system_clock_source_select.sv ----
// System clock source selector: picks a fast and a slow oscillator tick
// per configuration options, and lets software choose and divide one.
// Assumes every oscillator arrives as a one-cycle tick synchronous to clk.
//
// Contract
// - Six source types, four fast, two slow.
// - Exactly one fast, one slow source chosen.
// - Software picks fast or slow at run time.
// - Frequency set by speed bit and divider field.
// - Crystal range option, high at 1MHz up.
// - Dedicated option for 455kHz resonator mode.
// - Internal fast RC at 4, 8, 12MHz.
// - Slow oscillator also clocks watchdog and time base.
// - Slow crystal low-power bit, cleared at reset.
`timescale 1ns/10ps
module system_clock_source_select #(
  parameter int CNT_W = 7
) (
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  input  wire logic                             cyc_i,
  input  wire logic                             stb_i,
  input  wire logic                             we_i,
  input  wire logic [clk_sel_pkg::WB_AW-1:0]    adr_i,
  input  wire logic [clk_sel_pkg::WB_DW-1:0]    dat_i,
  input  wire logic [3:0]                       sel_i,
  output logic                                  ack_o,
  output logic [clk_sel_pkg::WB_DW-1:0]         dat_o,
  input  wire clk_sel_pkg::fast_src_t           fastSrcCfg,
  input  wire clk_sel_pkg::slow_src_t           slowSrcCfg,
  input  wire clk_sel_pkg::xtal_range_t         xtalRangeCfg,
  input  wire logic [1:0]                       rcFreqCfg,
  input  wire logic [clk_sel_pkg::NUM_FAST-1:0] fastTicks,
  input  wire logic [clk_sel_pkg::NUM_SLOW-1:0] slowTicks,
  output logic                                  sysClkEn,
  output logic                                  wdtClkEn,
  output logic                                  timeBaseClkEn,
  output logic                                  xtalHighRange,
  output logic                                  xtal455Mode,
  output clk_sel_pkg::rc_freq_t                 rcFreqSel,
  output logic                                  slowCrystalLowPower
);

  typedef struct packed {
    logic                          ack;
    logic [clk_sel_pkg::WB_DW-1:0] dat;
    logic                          speedSel;
    logic [clk_sel_pkg::DIV_W-1:0] divSel;
    logic                          lowPower;
    clk_sel_pkg::switch_state_t    sw;
    logic                          actFast;
    logic [clk_sel_pkg::DIV_W-1:0] actDiv;
    logic                          wdtEn;
    logic                          tbEn;
    logic                          xtalHigh;
    logic                          xtal455;
    clk_sel_pkg::rc_freq_t         rcFreq;
  } sel_state_t;

  sel_state_t q;
  sel_state_t d;

  clk_div_if divBus ();

  logic fastTick;
  logic slowTick;
  logic hit;
  logic wrMode;
  logic wrTb;

  // ----------------------------------------------------------------
  // Source choice
  // ----------------------------------------------------------------
  // The encodings leave no room for a no-oscillator choice.
  assign fastTick = fastTicks[fastSrcCfg];
  assign slowTick = slowTicks[slowSrcCfg];

  assign divBus.srcTick = q.actFast ? fastTick : slowTick;
  assign divBus.divSel  = q.actDiv;

  clk_tick_divider #(
    .CNT_W (CNT_W)
  ) u_div (
    .clk    (clk),
    .arst_n (arst_n),
    .bus    (divBus)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign hit    = cyc_i && stb_i && !q.ack;
  assign wrMode = hit && we_i && sel_i[0] && adr_i == clk_sel_pkg::ADR_SYS_MODE;
  assign wrTb   = hit && we_i && sel_i[0] && adr_i == clk_sel_pkg::ADR_TIME_BASE;

  always_comb begin
    d     = q;
    d.ack = hit;
    if (hit && !we_i) begin
      case (adr_i)
        clk_sel_pkg::ADR_SYS_MODE: begin
          d.dat = clk_sel_pkg::WB_DW'({q.speedSel, q.divSel});
        end
        clk_sel_pkg::ADR_TIME_BASE: begin
          d.dat = clk_sel_pkg::WB_DW'(q.lowPower);
        end
        clk_sel_pkg::ADR_STATUS: begin
          d.dat = clk_sel_pkg::WB_DW'({fastSrcCfg, slowSrcCfg, q.actDiv, q.sw, q.actFast});
        end
        default: begin
          d.dat = '0;
        end
      endcase
    end
    if (wrMode) begin
      d.speedSel = dat_i[clk_sel_pkg::SPEED_BIT];
      d.divSel   = dat_i[clk_sel_pkg::DIV_W-1:0];
    end
    if (wrTb) begin
      d.lowPower = dat_i[clk_sel_pkg::LP_BIT];
    end

    // ----------------------------------------------------------------
    // Handover
    // ----------------------------------------------------------------
    // A new source or divide only takes effect while the divider sits at
    // the start of a period, so no output period is ever cut short.
    case (q.sw)
      clk_sel_pkg::SW_RUN: begin
        if (q.speedSel != q.actFast || q.divSel != q.actDiv) begin
          d.sw = clk_sel_pkg::SW_PEND;
        end
      end
      clk_sel_pkg::SW_PEND: begin
        if (divBus.idle && !divBus.srcTick) begin
          d.actFast = q.speedSel;
          d.actDiv  = q.divSel;
          d.sw      = clk_sel_pkg::SW_RUN;
        end
      end
      default: begin
        d.sw = clk_sel_pkg::SW_RUN;
      end
    endcase

    // ----------------------------------------------------------------
    // Side clocks and analog option outputs
    // ----------------------------------------------------------------
    d.wdtEn    = slowTick;
    d.tbEn     = slowTick;
    d.xtalHigh = (xtalRangeCfg == clk_sel_pkg::XTAL_HIGH);
    d.xtal455  = (xtalRangeCfg == clk_sel_pkg::XTAL_455);
    case (rcFreqCfg)
      clk_sel_pkg::RC_8MHZ:  d.rcFreq = clk_sel_pkg::RC_8MHZ;
      clk_sel_pkg::RC_12MHZ: d.rcFreq = clk_sel_pkg::RC_12MHZ;
      default:               d.rcFreq = clk_sel_pkg::RC_4MHZ;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q          <= '0;
      q.speedSel <= clk_sel_pkg::SPEED_RST;
      q.divSel   <= clk_sel_pkg::DIV_RST;
      q.lowPower <= clk_sel_pkg::LP_RST;
      q.actFast  <= clk_sel_pkg::SPEED_RST;
      q.actDiv   <= clk_sel_pkg::DIV_RST;
      q.sw       <= clk_sel_pkg::SW_RUN;
      q.rcFreq   <= clk_sel_pkg::RC_4MHZ;
    end else begin
      q <= d;
    end
  end

  assign ack_o               = q.ack;
  assign dat_o               = q.dat;
  assign sysClkEn            = divBus.outTick;
  assign wdtClkEn            = q.wdtEn;
  assign timeBaseClkEn       = q.tbEn;
  assign xtalHighRange       = q.xtalHigh;
  assign xtal455Mode         = q.xtal455;
  assign rcFreqSel           = q.rcFreq;
  assign slowCrystalLowPower = q.lowPower;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_SPEED_WRITE: assert property (
    wrMode |=> q.speedSel == $past(dat_i[clk_sel_pkg::SPEED_BIT])
      && q.divSel == $past(dat_i[clk_sel_pkg::DIV_W-1:0]))
    else $error("mode write not stored");

  AST_HANDOVER: assert property (
    (q.sw == clk_sel_pkg::SW_PEND && divBus.idle && !divBus.srcTick)
      |=> q.actFast == $past(q.speedSel) && q.actDiv == $past(q.divSel))
    else $error("pending switch not applied");

  AST_NO_RUNT: assert property (
    ($changed(q.actFast) || $changed(q.actDiv)) |-> $past(divBus.idle) && !$past(divBus.srcTick))
    else $error("source switched mid period");

  AST_SLOW_TO_WDT: assert property (
    slowTick |=> wdtClkEn && timeBaseClkEn)
    else $error("slow tick not passed to side clocks");

  AST_SIDE_QUIET: assert property (
    !slowTick |=> !wdtClkEn ##0 !timeBaseClkEn)
    else $error("side clock without slow tick");

  AST_LOW_POWER: assert property (
    wrTb |=> slowCrystalLowPower == $past(dat_i[clk_sel_pkg::LP_BIT]))
    else $error("low-power bit not stored");

  AST_XTAL_RANGE: assert property (
    xtalRangeCfg == clk_sel_pkg::XTAL_HIGH |=> xtalHighRange && !xtal455Mode)
    else $error("crystal range option not applied");

  AST_RC_FREQ: assert property (
    rcFreqCfg == 2'h3 |=> rcFreqSel == clk_sel_pkg::RC_4MHZ)
    else $error("invalid RC code not mapped to 4MHz");

  AST_ACK_DROP: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule : system_clock_source_select

// ---- sim/system_clock_source_select_tb.sv ----
// Self-checking bench of the system clock source selector.
// Assumes the package, the carrier interface and the design modules are compiled first.
`timescale 1ns/10ps
module system_clock_source_select_tb;
  logic                       clk, arst_n, cyc, stb, we, ack, runTicks, cntOn, sideOn, prevSel, expSpeed, sp;
  logic                       sysClkEn, wdtClkEn, tbClkEn, xHi, x455, lowPwr;
  logic [3:0]                 adr, sel, fastTicks;
  logic [1:0]                 slowTicks, rcCfg;
  logic [2:0]                 d;
  logic [31:0]                datI, datO, rd, seed, rnd;
  clk_sel_pkg::fast_src_t     fsrc;
  clk_sel_pkg::slow_src_t     ssrc;
  clk_sel_pkg::xtal_range_t   xr;
  clk_sel_pkg::rc_freq_t      rcSel;
  int                         error_cnt, comparisons, cycles, tickCnt, pulseCnt, e;

  system_clock_source_select #(.CNT_W(7)) DUT (.clk(clk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(datI), .sel_i(sel), .ack_o(ack), .dat_o(datO), .fastSrcCfg(fsrc),
    .slowSrcCfg(ssrc), .xtalRangeCfg(xr), .rcFreqCfg(rcCfg), .fastTicks(fastTicks), .slowTicks(slowTicks),
    .sysClkEn(sysClkEn), .wdtClkEn(wdtClkEn), .timeBaseClkEn(tbClkEn), .xtalHighRange(xHi),
    .xtal455Mode(x455), .rcFreqSel(rcSel), .slowCrystalLowPower(lowPwr));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  function automatic logic [31:0] stat(input logic p, input logic [2:0] v, input logic [1:0] f, input logic s);
    return {24'h0, f, s, v, 1'b0, p};
  endfunction : stat

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Classic Wishbone cycle: request set after a rising edge, held until ack is sampled high
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv, input logic [3:0] s,
                    output logic [31:0] r);
    // Starting on a fresh edge keeps cyc low for at least one cycle between calls
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= dv; sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = datO;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Random source ticks, pulse counting and side clock checks
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
    seed      <= lfsr(seed);
    fastTicks <= runTicks ? seed[3:0] : 4'h0;
    slowTicks <= runTicks ? seed[5:4] : 2'h0;
    if (cntOn) begin
      if (expSpeed ? fastTicks[fsrc] : slowTicks[ssrc]) tickCnt++;
      if (sysClkEn === 1'b1) pulseCnt++;
    end
    if (sideOn) begin
      chk(wdtClkEn, prevSel);
      chk(tbClkEn, prevSel);
    end
    prevSel <= slowTicks[ssrc];
  end

  initial begin
    seed = 32'hca4627bf; rnd = 32'hca4627bf; cycles = 0; error_cnt = 0; comparisons = 0;
    arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0; datI = 32'h0;
    fsrc = clk_sel_pkg::SRC_EXT_FAST_CRYSTAL; ssrc = clk_sel_pkg::SRC_EXT_SLOW_CRYSTAL;
    xr = clk_sel_pkg::XTAL_LOW; rcCfg = 2'h0; runTicks = 1'b0; cntOn = 1'b0; sideOn = 1'b0;
    tickCnt = 0; pulseCnt = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, 4'h0, 32'h0, 4'hf, rd); chk(rd, 32'h8);
    wb(1'b0, 4'h4, 32'h0, 4'hf, rd); chk(rd, 32'h0);
    chk(lowPwr, 1'b0);
    wb(1'b1, 4'h4, 32'h1, 4'h1, rd);
    @(negedge clk); chk(lowPwr, 1'b1);
    // Low byte not enabled, so the bit must survive
    wb(1'b1, 4'h4, 32'h0, 4'he, rd);
    wb(1'b0, 4'h4, 32'h0, 4'hf, rd); chk(rd, 32'h1);
    wb(1'b1, 4'h4, 32'h0, 4'h1, rd);
    wb(1'b0, 4'hc, 32'h0, 4'hf, rd); chk(rd, 32'h0);
    // ----------------------------------------------------------------
    // Every configuration option code
    // ----------------------------------------------------------------
    for (int f = 0; f < 4; f++) begin
      for (int r = 0; r < 4; r++) begin
        fsrc <= clk_sel_pkg::fast_src_t'(f[1:0]); ssrc <= clk_sel_pkg::slow_src_t'(r[0]);
        xr <= clk_sel_pkg::xtal_range_t'(r[1:0]); rcCfg <= r[1:0];
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(xHi, r == 1);
        chk(x455, r == 2);
        chk(rcSel, (r == 3) ? 0 : r);
        wb(1'b0, 4'h8, 32'h0, 4'hf, rd); chk(rd, stat(1'b1, 3'h0, f[1:0], r[0]));
      end
    end
    @(negedge clk); sideOn = 1'b1;
    // ----------------------------------------------------------------
    // Switching under random traffic, corners first: fast undivided, slow divided by 128
    // ----------------------------------------------------------------
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      sp = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : rnd[0];
      d = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : rnd[3:1];
      runTicks <= 1'b1;
      wb(1'b1, 4'h0, {28'h0, sp, d}, 4'h1, rd);
      // A handover that never completes is ended by the global cycle limit
      do begin
        wb(1'b0, 4'h8, 32'h0, 4'hf, rd);
      end while (rd[1] !== 1'b0);
      chk(rd, stat(sp, d, 2'h3, 1'b1));
      @(negedge clk); expSpeed = sp; tickCnt = 0; pulseCnt = 0; cntOn = 1'b1;
      repeat (600) @(posedge clk);
      runTicks <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk); cntOn = 1'b0;
      // Counting may start mid-period, so one extra pulse is legal
      e = tickCnt >> d;
      if (pulseCnt == e + 1) e++;
      chk(pulseCnt, e);
    end
    test_done();
  end
endmodule : system_clock_source_select_tb
